/* File: design/reset_strap_config_select.sv */
`timescale 1ns/100ps
module reset_strap_config_select
    import strap_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    // Device pins
    input  wire logic                  master_reset_low,
    input  wire logic [GPIO_COUNT-1:0] gpio_in,
    // Device information block
    input  gpio_role_e [GPIO_COUNT-1:0] role_map,
    input  wire logic                  otp_programmed,
    // Stored configuration loader
    output logic                       otp_load_req,
    output logic [CFG_IDX_W-1:0]       otp_index,
    input  wire logic                  otp_load_done,
    input  wire logic                  otp_checksum_ok,
    input  dev_cfg_s                   otp_cfg,
    // External EEPROM search
    output logic                       eeprom_search_req,
    input  wire logic                  eeprom_search_done,
    // Bring-up controls
    output logic                       regulator_en,
    output logic                       int_clk_en,
    output logic                       pll_cal_start,
    input  wire logic                  pll_cal_done,
    input  wire logic                  pll_locked,
    // Software overwrite
    input  wire logic                  sw_strap_we,
    input  strap_cfg_s                 sw_strap,
    input  wire logic                  sw_dev_we,
    input  dev_cfg_s                   sw_dev,
    // Status and settings
    output strap_cfg_s                 strap_cfg,
    output dev_cfg_s                   dev_cfg,
    output logic [GPIO_COUNT-1:0]      captured_gpio,
    output logic                       cfg_loaded,
    output logic                       hold_pin_fault,
    output logic                       startup_done
);

    // Start-up sequence
    typedef enum logic [3:0] {
        ST_IN_RESET,
        ST_CAPTURE,
        ST_REG_UP,
        ST_CLK_UP,
        ST_PLL_CAL,
        ST_PLL_LOCK,
        ST_OTP_LOAD,
        ST_EEPROM,
        ST_READY
    } seq_state_e;

    logic [GPIO_COUNT-1:0] gpio_s;        // Synchronised pins
    logic                  nmr_s;         // Synchronised master reset
    logic                  nmr_d_reg;     // Delayed copy for edge detect
    logic                  nmr_rise;      // Release of master reset
    strap_cfg_s            decoded;       // Decode of captured levels

    seq_state_e            state_reg, state_next;
    logic [SETTLE_W-1:0]   cnt_reg, cnt_next;
    logic [GPIO_COUNT-1:0] cap_reg, cap_next;
    strap_cfg_s            strap_reg, strap_next;
    dev_cfg_s              dev_reg, dev_next;
    logic                  otp_req_reg, otp_req_next;
    logic                  ee_req_reg, ee_req_next;
    logic                  reg_en_reg, reg_en_next;
    logic                  clk_en_reg, clk_en_next;
    logic                  cal_reg, cal_next;
    logic                  loaded_reg, loaded_next;
    logic                  fault_reg, fault_next;
    logic                  done_reg, done_next;

    // Pins come from outside the clock domain
    gpio_sync #(.W(GPIO_COUNT + 1)) u_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .ce       (ce),
        .async_in ({master_reset_low, gpio_in}),
        .sync_out ({nmr_s, gpio_s})
    );

    // Turns captured levels into settings
    strap_decode u_decode (
        .captured (cap_reg),
        .role_map (role_map),
        .decoded  (decoded)
    );

    assign nmr_rise = nmr_s & ~nmr_d_reg;

    // Sequence, capture and derived settings
    always_comb
    begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        cap_next     = cap_reg;
        strap_next   = strap_reg;
        dev_next     = dev_reg;
        otp_req_next = 1'b0;
        ee_req_next  = ee_req_reg;
        reg_en_next  = reg_en_reg;
        clk_en_next  = clk_en_reg;
        cal_next     = 1'b0;
        loaded_next  = loaded_reg;
        fault_next   = fault_reg;
        done_next    = done_reg;
        if (!nmr_s)
        begin
            // Master reset held: settings and bring-up controls back to defaults; captured pins and fault flag kept
            state_next  = ST_IN_RESET;
            strap_next  = STRAP_RESET;
            dev_next    = DEV_RESET;
            ee_req_next = 1'b0;
            reg_en_next = 1'b0;
            clk_en_next = 1'b0;
            loaded_next = 1'b0;
            done_next   = 1'b0;
            // Low on the hold-high pin during reset is reported only
            if (!gpio_s[HOLD_HIGH_GPIO])
            begin
                fault_next = 1'b1;
            end
        end
        else
        begin
            case (state_reg)
                ST_IN_RESET:
                begin
                    if (nmr_rise)
                    begin
                        cap_next   = gpio_s;
                        state_next = ST_CAPTURE;
                    end
                end
                ST_CAPTURE:
                begin
                    strap_next  = decoded;
                    fault_next  = fault_reg;
                    reg_en_next = 1'b1;
                    cnt_next    = SETTLE_W'(REG_SETTLE_CYC);
                    state_next  = ST_REG_UP;
                end
                ST_REG_UP:
                begin
                    // Clocks wait for the regulators to settle
                    if (cnt_reg == '0)
                    begin
                        clk_en_next = 1'b1;
                        state_next  = ST_CLK_UP;
                    end
                    else
                    begin
                        cnt_next = cnt_reg - 1'b1;
                    end
                end
                ST_CLK_UP:
                begin
                    cal_next   = 1'b1;
                    state_next = ST_PLL_CAL;
                end
                ST_PLL_CAL:
                begin
                    if (pll_cal_done)
                    begin
                        state_next = ST_PLL_LOCK;
                    end
                end
                ST_PLL_LOCK:
                begin
                    if (pll_locked)
                    begin
                        // Blank parts hold no configurations to pick from
                        if (otp_programmed)
                        begin
                            otp_req_next = 1'b1;
                            state_next   = ST_OTP_LOAD;
                        end
                        else if (!strap_reg.eeprom_skip)
                        begin
                            ee_req_next = 1'b1;
                            state_next  = ST_EEPROM;
                        end
                        else
                        begin
                            state_next = ST_READY;
                        end
                    end
                end
                ST_OTP_LOAD:
                begin
                    if (otp_load_done)
                    begin
                        // A bad image is dropped whole, defaults stay
                        if (otp_checksum_ok)
                        begin
                            dev_next    = otp_cfg;
                            loaded_next = 1'b1;
                        end
                        if (!strap_reg.eeprom_skip)
                        begin
                            ee_req_next = 1'b1;
                            state_next  = ST_EEPROM;
                        end
                        else
                        begin
                            state_next = ST_READY;
                        end
                    end
                end
                ST_EEPROM:
                begin
                    if (eeprom_search_done)
                    begin
                        ee_req_next = 1'b0;
                        state_next  = ST_READY;
                    end
                end
                ST_READY:
                begin
                    done_next = 1'b1;
                    // Software may replace any derived setting
                    if (sw_strap_we)
                    begin
                        strap_next = sw_strap;
                    end
                    if (sw_dev_we)
                    begin
                        dev_next = sw_dev;
                    end
                end
                default:
                begin
                    state_next = ST_IN_RESET;
                end
            endcase
        end
    end

    // Registers; all state freezes while the enable is low
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            nmr_d_reg   <= 1'b0;
            state_reg   <= ST_IN_RESET;
            cnt_reg     <= '0;
            cap_reg     <= '0;
            strap_reg   <= STRAP_RESET;
            dev_reg     <= DEV_RESET;
            otp_req_reg <= 1'b0;
            ee_req_reg  <= 1'b0;
            reg_en_reg  <= 1'b0;
            clk_en_reg  <= 1'b0;
            cal_reg     <= 1'b0;
            loaded_reg  <= 1'b0;
            fault_reg   <= 1'b0;
            done_reg    <= 1'b0;
        end
        else if (ce)
        begin
            nmr_d_reg   <= nmr_s;
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            cap_reg     <= cap_next;
            strap_reg   <= strap_next;
            dev_reg     <= dev_next;
            otp_req_reg <= otp_req_next;
            ee_req_reg  <= ee_req_next;
            reg_en_reg  <= reg_en_next;
            clk_en_reg  <= clk_en_next;
            cal_reg     <= cal_next;
            loaded_reg  <= loaded_next;
            fault_reg   <= fault_next;
            done_reg    <= done_next;
        end
    end

    // Outputs straight from flip-flops
    assign otp_load_req      = otp_req_reg;
    assign otp_index         = strap_reg.cfg_index;
    assign eeprom_search_req = ee_req_reg;
    assign regulator_en      = reg_en_reg;
    assign int_clk_en        = clk_en_reg;
    assign pll_cal_start     = cal_reg;
    assign strap_cfg         = strap_reg;
    assign dev_cfg           = dev_reg;
    assign captured_gpio     = cap_reg;
    assign cfg_loaded        = loaded_reg;
    assign hold_pin_fault    = fault_reg;
    assign startup_done      = done_reg;

    // Release of master reset with the clock running
    sequence s_release;
        ce && nmr_s && nmr_rise && state_reg == ST_IN_RESET;
    endsequence

    // Decode step with the clock running
    sequence s_decode;
        ce && nmr_s && state_reg == ST_CAPTURE;
    endsequence

    a_capture_levels: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_release |=> cap_reg == $past(gpio_s))
        else $error("pins not captured at master reset release");

    a_proto_select: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_decode |=> strap_reg.aux_i2c == cap_reg[AUX_PROTO_GPIO])
        else $error("protocol select differs from captured pin");

    a_a2_spi_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_decode |=> !strap_reg.aux_i2c |-> !strap_reg.addr_a2)
        else $error("address strap active in SPI mode");

    a_sw_overwrite: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && nmr_s && state_reg == ST_READY && sw_strap_we |=> strap_reg == $past(sw_strap))
        else $error("software write did not replace strap settings");

    a_default_index: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_decode ##1 (ce && nmr_s && state_reg == ST_REG_UP) |->
            (role_map != {GPIO_COUNT{ROLE_NONE}}) || strap_reg.cfg_index ==
            {{(CFG_IDX_W - DFLT_SEL_BITS){1'b0}}, cap_reg[DFLT_SEL_BITS-1:0]})
        else $error("default select pins not used as index");

    a_eeprom_skip: assert property (@(posedge clk_sys) disable iff (!resetn)
        eeprom_search_req |-> !strap_reg.eeprom_skip)
        else $error("EEPROM searched although disabled");

    a_otp_blank: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(otp_load_req) |-> $past(otp_programmed))
        else $error("stored configuration requested on blank part");

    a_bad_checksum: assert property (@(posedge clk_sys) disable iff (!resetn)
        ce && nmr_s && state_reg == ST_OTP_LOAD && otp_load_done && !otp_checksum_ok
            |=> dev_cfg == DEV_RESET && !cfg_loaded)
        else $error("bad stored configuration was loaded");

    a_bringup_order: assert property (@(posedge clk_sys) disable iff (!resetn)
        pll_cal_start |-> regulator_en && int_clk_en)
        else $error("PLL calibration before supplies and clocks");

    a_reset_defaults: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg == ST_IN_RESET |-> dev_cfg == DEV_RESET)
        else $error("device settings not at defaults in reset");

    a_straps_held: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg == ST_READY && nmr_s && !sw_strap_we |=> $stable(strap_reg))
        else $error("strap settings changed without cause");

endmodule

/* File: common/strap_pkg.sv */
// What this block does
// - Capture all GPIO levels at master reset release
// - GPIO 9 low SPI, high I2C
// - Derived settings stay writable by software later
// - Address strap sets A2 only in I2C
// - Highest indexed address strap GPIO wins
// - EEPROM-disable high skips EEPROM search
// - Several EEPROM-disable GPIOs are ORed together
// - No select GPIOs: GPIO 3..0 form index
// - Pulled-up default pins select configuration 15
// - Select GPIOs packed lowest index as LSB
// - Fewer than four selects: upper bits zero
// - More than four selects widen the index
// - Index ignored on unprogrammed parts
// - Defaults: clock outputs off, GPIOs inputs
// - Bring up regulators, clocks, PLL calibrate, lock
// - Bad checksum leaves registers at defaults
package strap_pkg;

    // Pin counts
    localparam int GPIO_COUNT     = 10;
    localparam int CFG_IDX_W      = GPIO_COUNT;
    localparam int DFLT_SEL_BITS  = 4;
    localparam int NUM_CLK_OUT    = 8;
    localparam int AUX_PROTO_GPIO = 9;
    localparam int HOLD_HIGH_GPIO = 8;

    // Regulator settle wait, least time rounded up
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int REG_SETTLE_NS  = 100;
    localparam int REG_SETTLE_CYC = (REG_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETTLE_W       = 8;

    // Role that the device information block gives each GPIO
    typedef enum logic [1:0] {
        ROLE_NONE,
        ROLE_ADDR_A2,
        ROLE_EEPROM_DIS,
        ROLE_CFG_SEL
    } gpio_role_e;

    // Settings derived from the straps
    typedef struct packed {
        logic                 aux_i2c;
        logic                 addr_a2;
        logic                 eeprom_skip;
        logic [CFG_IDX_W-1:0] cfg_index;
    } strap_cfg_s;

    // Settings that a stored configuration may load
    typedef struct packed {
        logic [NUM_CLK_OUT-1:0] clk_out_en;
        logic [GPIO_COUNT-1:0]  gpio_out_mode;
    } dev_cfg_s;

    // Reset values
    localparam strap_cfg_s STRAP_RESET = '0;
    localparam dev_cfg_s   DEV_RESET   = '0;

endpackage

/* File: design/gpio_sync.sv */
`timescale 1ns/100ps
module gpio_sync
    import strap_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         ce,
    // Asynchronous levels in, synchronous levels out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;   // First stage, read only by the second
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;   // Second stage, safe to use
    logic [W-1:0] sync_next;

    // Next values; both stages freeze with the clock enable
    always_comb
    begin
        meta_next = ce ? async_in : meta_reg;
        sync_next = ce ? meta_reg : sync_reg;
    end

    // Pulled-up pins are assumed high at power-on
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_reg <= '1;
            sync_reg <= '1;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;

endmodule

/* File: design/strap_decode.sv */
`timescale 1ns/100ps
module strap_decode
    import strap_pkg::*;
(
    // Captured pin levels and roles of each pin
    input  wire logic [GPIO_COUNT-1:0] captured,
    input  gpio_role_e [GPIO_COUNT-1:0] role_map,
    // Decoded settings
    output strap_cfg_s                 decoded
);

    logic                 a2_val;     // Address strap level
    logic                 skip_val;   // OR of all EEPROM-disable pins
    logic                 any_sel;    // At least one select pin assigned
    logic [CFG_IDX_W-1:0] idx_val;    // Packed select index
    int                   pos;        // Next free index bit

    // Walk pins upward so later (higher) address straps overwrite
    always_comb
    begin
        a2_val   = 1'b0;
        skip_val = 1'b0;
        any_sel  = 1'b0;
        idx_val  = '0;
        pos      = 0;
        for (int i = 0; i < GPIO_COUNT; i++)
        begin
            case (role_map[i])
                ROLE_ADDR_A2:    a2_val = captured[i];
                ROLE_EEPROM_DIS: skip_val = skip_val | captured[i];
                ROLE_CFG_SEL:
                begin
                    // Non-consecutive pins pack from the LSB upward
                    idx_val[pos] = captured[i];
                    pos          = pos + 1;
                    any_sel      = 1'b1;
                end
                default: ;
            endcase
        end
        // No select pins: fall back to the low four, all high gives 15
        if (!any_sel)
        begin
            idx_val = {{(CFG_IDX_W - DFLT_SEL_BITS){1'b0}},
                       captured[DFLT_SEL_BITS-1:0]};
        end
        decoded.aux_i2c     = captured[AUX_PROTO_GPIO];
        decoded.addr_a2     = a2_val & captured[AUX_PROTO_GPIO];
        decoded.eeprom_skip = skip_val;
        decoded.cfg_index   = idx_val;
    end

endmodule

/* File: sim/strap_board.sv */
`timescale 1ns/100ps
module strap_board
    import strap_pkg::*;
(
    // Clock
    input  wire logic                  clk_sys,
    // Levels the board wants on the strap pins
    input  wire logic [GPIO_COUNT-1:0] straps,
    input  wire logic                  hold_bad,
    // Device pins
    output logic                       master_reset_low,
    output logic [GPIO_COUNT-1:0]      gpio_in
);
    // Reset line idles released
    initial master_reset_low = 1'b1;

    // Pin 8 is held high during reset unless a fault is staged on purpose
    always_comb
    begin
        gpio_in = straps;
        if (!master_reset_low)
        begin
            gpio_in[HOLD_HIGH_GPIO] = !hold_bad;
        end
    end

    // Reset pulse; called at a falling edge, straps stay put across the rise
    task automatic pulse(input int cycles);
        master_reset_low = 1'b0;
        repeat (cycles) @(negedge clk_sys);
        master_reset_low = 1'b1;
    endtask
endmodule

/* File: sim/reset_strap_config_select_bench.sv */
`timescale 1ns/100ps
module reset_strap_config_select_bench
    import strap_pkg::*;
;
    typedef gpio_role_e [GPIO_COUNT-1:0] role_arr_t;
    // One table row: roles, pin levels, part state, expected strap settings
    typedef struct packed {
        logic [19:0] roles;
        logic [9:0]  pins;
        logic        prog;
        logic        csok;
        logic [12:0] exp;
    } row_s;
    localparam dev_cfg_s OTP_CFG = 18'h2A5C3;

    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        ce = 1'b1;
    role_arr_t   role_map = role_arr_t'(20'h00000);
    logic        otp_programmed = 1'b0;
    logic        otp_load_done = 1'b0;
    logic        otp_checksum_ok = 1'b0;
    logic        eeprom_search_done = 1'b0;
    logic        pll_cal_done = 1'b0;
    logic        pll_locked = 1'b0;
    logic        sw_strap_we = 1'b0;
    strap_cfg_s  sw_strap = '0;
    logic        sw_dev_we = 1'b0;
    dev_cfg_s    sw_dev = '0;
    logic [9:0]  straps = 10'h3FF;
    logic        hold_bad = 1'b0;
    logic        master_reset_low, otp_load_req, eeprom_search_req, regulator_en;
    logic        int_clk_en, pll_cal_start, cfg_loaded, hold_pin_fault, startup_done;
    logic [9:0]  otp_index, gpio_in, captured_gpio;
    strap_cfg_s  strap_cfg;
    dev_cfg_s    dev_cfg;
    logic        saw_otp, saw_eep, saw_cal;
    int          num_errors = 0;
    int          samples_checked = 0;
    row_s        rows [8];

    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;

    strap_board board (.clk_sys(clk_sys), .straps(straps), .hold_bad(hold_bad),
        .master_reset_low(master_reset_low), .gpio_in(gpio_in));

    reset_strap_config_select dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .master_reset_low(master_reset_low), .gpio_in(gpio_in), .role_map(role_map),
        .otp_programmed(otp_programmed), .otp_load_req(otp_load_req),
        .otp_index(otp_index), .otp_load_done(otp_load_done),
        .otp_checksum_ok(otp_checksum_ok), .otp_cfg(OTP_CFG),
        .eeprom_search_req(eeprom_search_req), .eeprom_search_done(eeprom_search_done),
        .regulator_en(regulator_en), .int_clk_en(int_clk_en),
        .pll_cal_start(pll_cal_start), .pll_cal_done(pll_cal_done),
        .pll_locked(pll_locked), .sw_strap_we(sw_strap_we), .sw_strap(sw_strap),
        .sw_dev_we(sw_dev_we), .sw_dev(sw_dev), .strap_cfg(strap_cfg),
        .dev_cfg(dev_cfg), .captured_gpio(captured_gpio), .cfg_loaded(cfg_loaded),
        .hold_pin_fault(hold_pin_fault), .startup_done(startup_done));

    // Loader and search answer one cycle after each request; PLL done and lock follow the internal clock enable int_clk_en
    always @(negedge clk_sys)
    begin
        otp_load_done      <= otp_load_req;
        eeprom_search_done <= eeprom_search_req;
        pll_cal_done       <= int_clk_en;
        pll_locked         <= int_clk_en;
    end

    // Note which requests were raised during a start-up
    always @(posedge clk_sys)
    begin
        if (otp_load_req) saw_otp = 1'b1;
        if (eeprom_search_req) saw_eep = 1'b1;
        if (pll_cal_start) saw_cal = 1'b1;
    end

    // Single compare; case inequality so an unknown never matches
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Bounded wait for the end of the start-up sequence
    task automatic wait_done();
        int n;
        n = 0;
        while (startup_done !== 1'b1 && n < 500)
        begin
            @(negedge clk_sys);
            n++;
        end
        // A late finish on the last pass still counts as a finish
        if (startup_done !== 1'b1)
        begin
            check("startup_done", 1, startup_done);
            complete_run();
        end
    endtask

    // One start-up with the row's straps, then compare everything it settles
    task automatic run_row(input row_s r);
        logic ld;
        ld = r.prog & r.csok;
        role_map = role_arr_t'(r.roles);
        otp_programmed = r.prog;
        otp_checksum_ok = r.csok;
        straps = r.pins;
        repeat (4) @(negedge clk_sys);
        saw_otp = 1'b0;
        saw_eep = 1'b0;
        saw_cal = 1'b0;
        board.pulse(6);
        wait_done();
        check("captured_gpio", r.pins, captured_gpio);
        check("strap_cfg", r.exp, strap_cfg);
        check("otp_index", r.exp[9:0], otp_index);
        check("otp_req", r.prog, saw_otp);
        check("eeprom_req", !r.exp[10], saw_eep);
        check("cfg_loaded", ld, cfg_loaded);
        check("dev_cfg", ld ? OTP_CFG : 18'h00000, dev_cfg);
        check("bringup", 2'h3, {regulator_en, int_clk_en});
        check("pll_cal", 1, saw_cal);
        $display("test row done");
    endtask

    initial
    begin
        // roles, pins, programmed, checksum ok, expected strap settings
        rows[0] = {20'h00000, 10'h3FF, 1'b1, 1'b1, 13'h100F}; // pulled-up default
        rows[1] = {20'h00000, 10'h105, 1'b1, 1'b0, 13'h0005}; // bad checksum
        rows[2] = {20'h04400, 10'h38A, 1'b0, 1'b0, 13'h180A}; // two address straps
        rows[3] = {20'h04000, 10'h18F, 1'b1, 1'b1, 13'h000F}; // address strap in SPI
        rows[4] = {20'h02200, 10'h343, 1'b1, 1'b1, 13'h1403}; // two disable straps
        rows[5] = {20'h0FC30, 10'h1B5, 1'b1, 1'b1, 13'h000B}; // scattered selects
        rows[6] = {20'h00C30, 10'h3FF, 1'b0, 1'b0, 13'h1003}; // two selects
        rows[7] = {20'h03F3C, 10'h3EF, 1'b1, 1'b1, 13'h101B}; // five selects
        repeat (4) @(negedge clk_sys);
        check("dev_cfg", 18'h00000, dev_cfg);
        check("startup_done", 0, startup_done);
        repeat (4) @(negedge clk_sys);
        resetn = 1'b1;
        wait_done();
        // No row gives a strap role to a test-port pin
        foreach (rows[i]) run_row(rows[i]);
        // Pins moving after capture leave the captured copy alone
        straps = 10'h000;
        repeat (10) @(negedge clk_sys);
        check("captured_held", 10'h3EF, captured_gpio);
        check("strap_held", 13'h101B, strap_cfg);
        check("hold_pin_fault", 0, hold_pin_fault);
        $display("test hold done");
        // Back-to-back software writes replace the derived settings
        // A write offered while the enable is low must not land
        ce = 1'b0;
        sw_strap_we = 1'b1;
        sw_strap = 13'h0ABC;
        @(negedge clk_sys);
        check("ce_freeze", 13'h101B, strap_cfg);
        ce = 1'b1;
        @(negedge clk_sys);
        sw_strap_we = 1'b0;
        sw_dev_we = 1'b1;
        sw_dev = 18'h155AA;
        @(negedge clk_sys);
        sw_dev_we = 1'b0;
        @(negedge clk_sys);
        check("sw_strap", 13'h0ABC, strap_cfg);
        check("sw_dev", 18'h155AA, dev_cfg);
        $display("test write done");
        // Pin 8 pulled low during reset is flagged and sticks
        hold_bad = 1'b1;
        run_row({20'h00000, 10'h3FF, 1'b0, 1'b0, 13'h100F});
        hold_bad = 1'b0;
        check("hold_pin_fault", 1, hold_pin_fault);
        $display("test fault done");
        complete_run();
    end
endmodule
